// file: logic/splc_pkg.sv
// Package with constants and types for the stack pointer limit checker.
// Summary of operation
// - The stack pointer always points at the first free word and the stack grows toward higher addresses.
// - A pop decrements the stack pointer before the access and a push increments it after the access.
// - A program counter pushed by a call has its most significant byte forced to zero.
// - A program counter pushed during exception processing carries the low status byte in its top byte.
// - The stack limit register bounds the stack from above and is not initialised by reset.
// - Bit 0 of the stack limit register always reads as zero whatever is written.
// - Only a push effective address is compared with the stack limit; pop and reference addresses are not.
// - A push with the pointer equal to the limit does not trap, but the next push does.
// - A stack pointer address below 0800h raises an underflow stack error trap.
package splc_pkg;
    localparam int unsigned SPLC_WIDTH       = 16;
    localparam logic [15:0] SPLC_SFR_TOP     = 16'h0800;
    localparam logic [15:0] SPLC_WORD_STEP   = 16'h0002;
    localparam logic [15:0] SPLC_ALIGN_MASK  = 16'hFFFE;
    localparam logic [15:0] SPLC_SP_RESET    = 16'h0800;
    localparam int unsigned SPLC_MSB_LO      = 8;

    typedef enum logic [1:0] {
        SPLC_OP_NONE,
        SPLC_OP_PUSH,
        SPLC_OP_POP,
        SPLC_OP_REF
    } splc_op_t;

    typedef enum logic [1:0] {
        SPLC_PUSH_DATA,
        SPLC_PUSH_CALL,
        SPLC_PUSH_EXC
    } splc_kind_t;
endpackage : splc_pkg

// file: logic/splc_cmp_if.sv
// Interface between the checker top and its address comparator.
`timescale 1ns/10ps
interface splc_cmp_if;
    logic [15:0] ea;
    logic [15:0] limit;
    logic        is_push;
    logic        check;
    logic        overflow;
    logic        underflow;
    modport top (output ea, output limit, output is_push, output check, input overflow, input underflow);
    modport cmp (input ea, input limit, input is_push, input check, output overflow, output underflow);
endinterface : splc_cmp_if

// file: logic/splc_cmp.sv
// Combinational stack address comparator.
`timescale 1ns/10ps
module splc_cmp (
    splc_cmp_if.cmp cif
);
    import splc_pkg::*;

    always_comb begin
        cif.overflow  = cif.check && cif.is_push && (cif.ea > cif.limit);
        cif.underflow = cif.check && (cif.ea < SPLC_SFR_TOP);
    end
endmodule : splc_cmp

// file: logic/splc_top.sv
// Stack pointer, stack limit and stack error trap logic.
`timescale 1ns/10ps
module splc_top (
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 enable_i,
    input  wire splc_pkg::splc_op_t   op_i,
    input  wire splc_pkg::splc_kind_t kind_i,
    input  wire logic [15:0]          data_i,
    input  wire logic [15:0]          offset_i,
    input  wire logic [7:0]           status_low_byte_i,
    input  wire logic                 sp_write_i,
    input  wire logic                 limit_write_i,
    input  wire logic [15:0]          write_data_i,
    input  wire logic                 trap_ack_i,
    output logic [15:0]               stack_pointer_reg_o,
    output logic [15:0]               stack_limit_reg_o,
    output logic [15:0]               access_addr_o,
    output logic [15:0]               access_data_o,
    output logic                      access_valid_o,
    output logic                      access_write_o,
    output logic                      trap_req_o
);
    import splc_pkg::*;

    splc_cmp_if cif ();

    splc_cmp u_cmp (
        .cif (cif)
    );

    logic [15:0] stack_pointer_reg;
    logic [15:0] next_stack_pointer_reg;
    logic [15:0] stack_limit_reg;
    logic [15:0] next_stack_limit_reg;
    logic [15:0] access_addr;
    logic [15:0] next_access_addr;
    logic [15:0] access_data;
    logic [15:0] next_access_data;
    logic        access_valid;
    logic        next_access_valid;
    logic        access_write;
    logic        next_access_write;
    logic        trap_req;
    logic        next_trap_req;
    logic [15:0] ea;

    function automatic logic [15:0] splc_push_word(input splc_kind_t kind, input logic [15:0] data,
                                                   input logic [7:0] status_low_byte);
        logic [15:0] word;
        word = data;
        unique case (kind)
            SPLC_PUSH_DATA: word = data;
            SPLC_PUSH_CALL: word = {8'h00, data[7:0]};
            SPLC_PUSH_EXC:  word = {status_low_byte, data[7:0]};
            default:        word = data;
        endcase
        return word;
    endfunction : splc_push_word

    always_comb begin
        unique case (op_i)
            SPLC_OP_POP: ea = stack_pointer_reg - SPLC_WORD_STEP;
            SPLC_OP_REF: ea = (stack_pointer_reg + offset_i) & SPLC_ALIGN_MASK;
            default:     ea = stack_pointer_reg;
        endcase
    end

    assign cif.ea      = ea;
    assign cif.limit   = stack_limit_reg;
    assign cif.is_push = (op_i == SPLC_OP_PUSH);
    assign cif.check   = enable_i && (op_i != SPLC_OP_NONE);

    always_comb begin
        next_stack_pointer_reg = stack_pointer_reg;
        next_stack_limit_reg   = stack_limit_reg;
        next_access_addr       = access_addr;
        next_access_data       = access_data;
        next_access_valid      = 1'b0;
        next_access_write      = 1'b0;
        next_trap_req          = trap_req;
        if (trap_ack_i) begin
            next_trap_req = 1'b0;
        end
        if (cif.overflow || cif.underflow) begin
            next_trap_req = 1'b1;
        end
        if (limit_write_i) begin
            next_stack_limit_reg = write_data_i & SPLC_ALIGN_MASK;
        end
        if (sp_write_i) begin
            next_stack_pointer_reg = write_data_i & SPLC_ALIGN_MASK;
        end else begin
            unique case (op_i)
                SPLC_OP_PUSH: begin
                    next_access_addr       = stack_pointer_reg;
                    next_access_data       = splc_push_word(kind_i, data_i, status_low_byte_i);
                    next_access_valid      = 1'b1;
                    next_access_write      = 1'b1;
                    next_stack_pointer_reg = stack_pointer_reg + SPLC_WORD_STEP;
                end
                SPLC_OP_POP: begin
                    next_access_addr       = ea;
                    next_access_valid      = 1'b1;
                    next_stack_pointer_reg = ea;
                end
                SPLC_OP_REF: begin
                    next_access_addr  = ea;
                    next_access_valid = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            stack_pointer_reg <= SPLC_SP_RESET;
            access_addr       <= 16'h0000;
            access_data       <= 16'h0000;
            access_valid      <= 1'b0;
            access_write      <= 1'b0;
            trap_req          <= 1'b0;
        end else if (enable_i) begin
            stack_pointer_reg <= next_stack_pointer_reg;
            access_addr       <= next_access_addr;
            access_data       <= next_access_data;
            access_valid      <= next_access_valid;
            access_write      <= next_access_write;
            trap_req          <= next_trap_req;
        end
    end

    // limit not reset
    // The limit holds no reset on purpose; software must load it before relying on overflow traps.
    always_ff @(posedge clock_i) begin
        if (enable_i) begin
            stack_limit_reg <= next_stack_limit_reg;
        end
    end

    assign stack_pointer_reg_o = stack_pointer_reg;
    assign stack_limit_reg_o   = stack_limit_reg;
    assign access_addr_o       = access_addr;
    assign access_data_o       = access_data;
    assign access_valid_o      = access_valid;
    assign access_write_o      = access_write;
    assign trap_req_o          = trap_req;
endmodule : splc_top

// file: bench/splc_exc_model.sv
// Core exception logic model that accepts stack error trap requests.
`timescale 1ns/10ps
module splc_exc_model (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic trap_req_i,
    input  wire logic slow_i,
    output logic      trap_ack_o
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wait_cnt <= 4'h0;
            trap_ack_o <= 1'b0;
        end else begin
            trap_ack_o <= trap_req_i && !trap_ack_o && wait_cnt == (slow_i ? 4'h8 : 4'h1);
            wait_cnt <= (trap_req_i && !trap_ack_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : splc_exc_model

// file: bench/splc_checker.sv
// Concurrent checks on the stack pointer limit checker ports.
`timescale 1ns/10ps
module splc_checker (
    input wire logic clock_i, reset_i, enable_i, sp_write_i, limit_write_i, trap_ack_i,
    input wire logic access_valid_o, access_write_o, trap_req_o,
    input wire splc_pkg::splc_op_t op_i,
    input wire splc_pkg::splc_kind_t kind_i,
    input wire logic [15:0] write_data_i, stack_pointer_reg_o, stack_limit_reg_o, access_addr_o, access_data_o,
    input wire logic [7:0] status_low_byte_i
);
    import splc_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    wire [15:0] sp = stack_pointer_reg_o;
    wire push = enable_i && op_i == SPLC_OP_PUSH && !sp_write_i;
    wire pop = enable_i && op_i == SPLC_OP_POP && !sp_write_i;
    AST_PUSH_STEP: assert property (
        push && !sp_write_i |=> access_valid_o && access_write_o && access_addr_o == $past(sp) && sp == $past(sp) + 16'h0002)
        else $error("push step");
    AST_POP_STEP: assert property (
        pop |=> access_addr_o == sp && sp == $past(sp) - 16'h0002) else $error("pop step");
    AST_CALL_ZERO: assert property (
        push && kind_i == SPLC_PUSH_CALL |=> access_data_o[15:8] == 8'h00) else $error("call byte");
    AST_EXC_MERGE: assert property (
        push && kind_i == SPLC_PUSH_EXC |=> access_data_o[15:8] == $past(status_low_byte_i)) else $error("exc byte");
    AST_LIMIT_LOAD: assert property (
        enable_i && limit_write_i |=> stack_limit_reg_o == ($past(write_data_i) & 16'hfffe)) else $error("limit");
    AST_OVERFLOW: assert property (
        push && sp > stack_limit_reg_o |=> trap_req_o) else $error("overflow");
    AST_UNDERFLOW: assert property (
        pop && sp < 16'h0802 && sp >= 16'h0002 |=> trap_req_o) else $error("underflow");
    AST_TRAP_HOLD: assert property (
        trap_req_o && !trap_ack_i |=> trap_req_o) else $error("trap dropped");
endmodule : splc_checker
bind splc_top splc_checker i_splc_checker (.*);

// file: bench/splc_top_tb.sv
// Self-checking bench for the stack pointer limit checker.
`timescale 1ns/10ps
module splc_top_tb;
    import splc_pkg::*;
    logic clock_i = 0, reset_i = 1, enable_i = 1, sp_write_i = 0, limit_write_i = 0, trap_ack_i, slow = 0;
    splc_op_t op_i = SPLC_OP_NONE;
    splc_kind_t kind_i = SPLC_PUSH_DATA;
    logic [15:0] data_i = 0, offset_i = 0, write_data_i = 0, sp_o, lim_o, addr_o, dat_o, sp, w;
    logic [7:0] status_low_byte_i = 0;
    logic valid_o, wr_o, trap_o;
    logic [31:0] rnd = 32'h894f;
    int err_count = 0, samples_checked = 0, cyc = 0;
    splc_top i_splc_top (.clock_i, .reset_i, .enable_i, .op_i, .kind_i, .data_i, .offset_i, .status_low_byte_i,
        .sp_write_i, .limit_write_i, .write_data_i, .trap_ack_i, .stack_pointer_reg_o(sp_o), .stack_limit_reg_o(lim_o),
        .access_addr_o(addr_o), .access_data_o(dat_o), .access_valid_o(valid_o), .access_write_o(wr_o), .trap_req_o(trap_o));
    splc_exc_model i_splc_exc_model (.clock_i, .reset_i, .trap_req_i(trap_o), .slow_i(slow), .trap_ack_o(trap_ack_i));
    initial forever #10 clock_i = ~clock_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] word(input splc_kind_t k, input logic [15:0] d, input logic [7:0] s);
        return k == SPLC_PUSH_CALL ? {8'h00, d[7:0]} : k == SPLC_PUSH_EXC ? {s, d[7:0]} : d;
    endfunction : word
    task close_out;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task step(input splc_op_t o, input splc_kind_t k, input logic [15:0] off);
        rnd = lfsr(rnd);
        w = rnd[15:0];
        @(posedge clock_i);
        op_i <= o;
        kind_i <= k;
        data_i <= w;
        offset_i <= off;
        status_low_byte_i <= rnd[23:16];
        @(posedge clock_i);
        op_i <= SPLC_OP_NONE;
        #1;
    endtask : step
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 0;
        @(posedge clock_i);
        limit_write_i <= 1;
        write_data_i <= 16'h0805;
        @(posedge clock_i);
        limit_write_i <= 0;
        // idle gap after the limit write.
        @(posedge clock_i);
        chk(lim_o, 16'h0804);
        sp = SPLC_SP_RESET;
        for (int i = 0; i < 4; i++) begin
            step(SPLC_OP_PUSH, splc_kind_t'(i % 3), 16'h0000);
            chk(addr_o, sp);
            chk(dat_o, word(kind_i, w, status_low_byte_i));
            chk(16'({valid_o, wr_o, trap_o}), 16'({2'b11, sp > 16'h0804}));
            sp += 16'h0002;
            chk(sp_o, sp);
        end
        repeat (6) @(posedge clock_i);
        for (int i = 0; i < 5; i++) begin
            step(SPLC_OP_POP, SPLC_PUSH_DATA, 16'h0000);
            sp -= 16'h0002;
            chk(addr_o, sp);
            chk(16'(trap_o), 16'(sp < SPLC_SFR_TOP));
        end
        repeat (6) @(posedge clock_i);
        slow <= 1;
        step(SPLC_OP_REF, SPLC_PUSH_DATA, 16'hfff0);
        repeat (3) @(posedge clock_i);
        chk(16'(trap_o), 16'h0001);
        sp_write_i <= 1;
        write_data_i <= 16'h0901;
        @(posedge clock_i);
        sp_write_i <= 0;
        @(posedge clock_i);
        #1;
        chk(sp_o, 16'h0900);
        close_out();
    end
endmodule : splc_top_tb
